// [hdl/dccd_top.sv]
// dac configuration command decoder: takes serial frames and keeps the global control registers
// assumes channel settings and code storage live elsewhere and act on the pulses given here
//
// Contract
// - update command moves input register to output
// - configuration bit 23 set: software reset
// - trip-disable bit stops thermal channel shutdown
// - outside reference bit stops reference node charging
// - crc bit enables frame cyclic redundancy checking; here the bit is only stored and no check is made
// - power-down mask, one bit per channel
// - pick bit steers code writes to A/B
// - soft toggle edges update from A or B
// - toggle/dither only while enable bit set
// - mux command bit 18 turns monitor on
// - mux command bits 17:8 select monitored signal
// - three fault flags, readable, writable, reset zero
// - broadcast writes one code to every channel
// - 12-bit variant takes code from 23:12
// - bit x of each mask governs channel x
// - per-channel toggle source: three pins or software
// - reads return same layout as writes
`timescale 1ns/1ps

module dccd_top #(
    parameter bit CODE_IS_12BIT = 1'b0
) (
    // system clock and reset
    input  wire logic                  clk_sys,
    input  wire logic                  rst,
    // serial link
    input  wire logic                  sclk,
    input  wire logic                  csN,
    input  wire logic                  sdi,
    output logic                       sdo,
    // pins from the analog side
    input  wire logic                  thermalOverload,
    input  wire logic [2:0]            togglePin,
    // per-channel toggle source, from the channel settings
    input  wire logic [7:0][1:0]       toggleSourceSelect,
    // register contents and derived controls
    output dccd_pkg::dccd_regs_t       regView,
    output logic [7:0]                 chanShutdown,
    output logic                       refCompChargeOn,
    // output register transfers
    output logic [7:0]                 dacLoad,
    output logic [7:0]                 dacLoadFromB,
    // input register writes
    output logic [7:0]                 codeWrite,
    output logic [7:0]                 codeWriteToB,
    output logic [15:0]                codeValue,
    // commands served by other blocks
    output logic                       passValid,
    output dccd_pkg::dccd_frame_t      passFrame
);

    dccd_pkg::dccd_sys_t   sR;
    dccd_pkg::dccd_sys_t   sN;
    dccd_pkg::dccd_frame_t linkFrame;
    logic                  linkToggle;
    logic [7:0]            effToggle;
    logic [7:0]            toggleEvent;
    logic [23:0]           readData;
    logic [7:0]            cmd;
    logic [23:0]           d;

    dccd_link u_link (
        .sclk        (sclk),
        .csN         (csN),
        .sdi         (sdi),
        .sdo         (sdo),
        .rst         (rst),
        .readWord    (sR.readWord),
        .frameHold   (linkFrame),
        .frameToggle (linkToggle)
    );

    assign cmd = sR.frame.cmd;
    assign d   = sR.frame.data;

    // source 0 is the software bit, sources 1 to 3 are the synchronised pins
    genvar gi;
    for (gi = 0; gi < dccd_pkg::CHANNELS; gi++) begin : gToggle
        logic [3:0] src;
        assign src           = {sR.pinSync, sR.regs.softToggleBits[gi]};
        assign effToggle[gi] = src[toggleSourceSelect[gi]];
    end

    // an edge on a disabled channel is tracked but never moves the output
    assign toggleEvent = (effToggle ^ sR.toggleLevel) & sR.regs.toggleDitherEnableBits;

    // readback in the same bit positions the write used
    always_comb begin
        readData = '0;
        case (cmd[2:0])
            3'h0: begin
                readData[dccd_pkg::TRIP_DISABLE_BIT] = sR.regs.cfg.thermalTripDisable;
                readData[dccd_pkg::OUTSIDE_REF_BIT]  = sR.regs.cfg.outsideReferenceSelect;
                readData[dccd_pkg::SPI_CRC_BIT]      = sR.regs.cfg.spiCrcOn;
            end
            3'h1: begin
                readData[dccd_pkg::CHAN_LSB +: 8] = sR.regs.channelSleepBits;
            end
            3'h2: begin
                readData[dccd_pkg::CHAN_LSB +: 8] = sR.regs.inputPickBits;
            end
            3'h3: begin
                readData[dccd_pkg::CHAN_LSB +: 8] = sR.regs.softToggleBits;
            end
            3'h4: begin
                readData[dccd_pkg::CHAN_LSB +: 8] = sR.regs.toggleDitherEnableBits;
            end
            3'h5: begin
                readData[dccd_pkg::MUX_ON_BIT] = sR.regs.monitorMuxOn;
                readData[dccd_pkg::MUX_SEL_MSB:dccd_pkg::MUX_SEL_LSB] = sR.regs.monitorMuxSelect;
            end
            3'h6: begin
                readData[dccd_pkg::THERMAL_FLAG_BIT] = sR.regs.faults.thermalTripFlag;
                readData[dccd_pkg::CLOCK_FLAG_BIT]   = sR.regs.faults.clockIntegrityFlag;
                readData[dccd_pkg::COMMAND_FLAG_BIT] = sR.regs.faults.commandIntegrityFlag;
            end
            3'h7: begin
                readData[dccd_pkg::THERMAL_FLAG_BIT] = sR.thermSync;
            end
            default: begin
                readData = '0;
            end
        endcase
    end

    always_comb begin
        sN = sR;
        // outside inputs pass two flops before use
        sN.thermMeta = thermalOverload;
        sN.thermSync = sR.thermMeta;
        sN.pinMeta   = togglePin;
        sN.pinSync   = sR.pinMeta;
        sN.togMeta   = linkToggle;
        sN.togSync   = sR.togMeta;
        sN.togSeen   = sR.togSync;
        sN.dacLoad   = '0;
        sN.codeWrite = '0;
        sN.passValid = 1'b0;
        case (sR.phase)
            dccd_pkg::ST_IDLE: begin
                if (sR.togSync != sR.togSeen) begin
                    sN.frame = linkFrame;
                    sN.phase = dccd_pkg::ST_EXEC;
                end
            end
            dccd_pkg::ST_EXEC: begin
                sN.phase = dccd_pkg::ST_IDLE;
                case (cmd)
                    dccd_pkg::CMD_CONFIG: begin
                        if (d[dccd_pkg::SOFT_RESET_BIT]) begin
                            // reset wins over whatever else the same word carries
                            sN.regs = dccd_pkg::REGS_RESET;
                        end else begin
                            sN.regs.cfg.thermalTripDisable =
                                d[dccd_pkg::TRIP_DISABLE_BIT];
                            sN.regs.cfg.outsideReferenceSelect =
                                d[dccd_pkg::OUTSIDE_REF_BIT];
                            sN.regs.cfg.spiCrcOn =
                                d[dccd_pkg::SPI_CRC_BIT];
                        end
                    end
                    dccd_pkg::CMD_SLEEP: begin
                        sN.regs.channelSleepBits = d[dccd_pkg::CHAN_LSB +: 8];
                    end
                    dccd_pkg::CMD_PICK: begin
                        sN.regs.inputPickBits = d[dccd_pkg::CHAN_LSB +: 8];
                    end
                    dccd_pkg::CMD_SOFT_TOGGLE: begin
                        // the edge itself is seen next cycle through effToggle
                        sN.regs.softToggleBits = d[dccd_pkg::CHAN_LSB +: 8];
                    end
                    dccd_pkg::CMD_TD_ENABLE: begin
                        sN.regs.toggleDitherEnableBits =
                            d[dccd_pkg::CHAN_LSB +: 8];
                    end
                    dccd_pkg::CMD_MUX: begin
                        sN.regs.monitorMuxOn = d[dccd_pkg::MUX_ON_BIT];
                        sN.regs.monitorMuxSelect =
                            d[dccd_pkg::MUX_SEL_MSB:dccd_pkg::MUX_SEL_LSB];
                    end
                    dccd_pkg::CMD_FAULT: begin
                        sN.regs.faults.thermalTripFlag = d[dccd_pkg::THERMAL_FLAG_BIT];
                        sN.regs.faults.clockIntegrityFlag = d[dccd_pkg::CLOCK_FLAG_BIT];
                        sN.regs.faults.commandIntegrityFlag = d[dccd_pkg::COMMAND_FLAG_BIT];
                    end
                    dccd_pkg::CMD_BROADCAST: begin
                        sN.codeWrite    = '1;
                        sN.codeWriteToB = sR.regs.inputPickBits;
                        if (CODE_IS_12BIT) begin
                            sN.codeValue =
                                {4'h0, d[dccd_pkg::CODE_MSB:dccd_pkg::CODE12_LSB]};
                        end else begin
                            sN.codeValue = d[dccd_pkg::CODE_MSB:dccd_pkg::CODE16_LSB];
                        end
                    end
                    default: begin
                        if (cmd[7:4] == dccd_pkg::NIB_UPDATE) begin
                            // channel numbers 8 to 15 name no channel
                            if (cmd[3] == 1'b0) begin
                                sN.dacLoad[cmd[2:0]] = 1'b1;
                            end else begin
                                sN.regs.faults.commandIntegrityFlag = 1'b1;
                            end
                        end else if (cmd == dccd_pkg::CMD_NOP) begin
                            sN.phase = dccd_pkg::ST_IDLE;
                        end else if (cmd[7:4] == dccd_pkg::NIB_READ_GLOBAL) begin
                            if (cmd[3] == 1'b0) begin
                                sN.readWord = {cmd, readData};
                            end else begin
                                sN.regs.faults.commandIntegrityFlag = 1'b1;
                            end
                        end else if ((cmd[7:4] <= dccd_pkg::NIB_CHAN_WR_LAST)
                                || ((cmd[7:4] >= dccd_pkg::NIB_CHAN_RD_LO)
                                    && (cmd[7:4] <= dccd_pkg::NIB_CHAN_RD_HI))
                                || ((cmd >= dccd_pkg::CMD_EXTRA_LO)
                                    && (cmd <= dccd_pkg::CMD_EXTRA_HI))) begin
                            sN.passValid = 1'b1;
                            sN.passFrame = sR.frame;
                        end else begin
                            sN.regs.faults.commandIntegrityFlag = 1'b1;
                        end
                    end
                endcase
            end
            default: begin
                sN.phase = dccd_pkg::ST_IDLE;
            end
        endcase
        // a toggle edge and an update command on the same channel give one transfer
        sN.toggleLevel  = effToggle;
        sN.dacLoad      = sN.dacLoad | toggleEvent;
        sN.dacLoadFromB = effToggle & sR.regs.toggleDitherEnableBits;
        // hardware setting the flag wins over a clear written in the same cycle
        if (sR.thermSync) begin
            sN.regs.faults.thermalTripFlag = 1'b1;
        end
        // shutdown follows the overload level; disabling it keeps channels running
        sN.chanShutdown    = {8{sR.thermSync & ~sR.regs.cfg.thermalTripDisable}};
        sN.refCompChargeOn = ~sR.regs.cfg.outsideReferenceSelect;
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            sR <= dccd_pkg::SYS_RESET;
        end else begin
            sR <= sN;
        end
    end

    assign regView         = sR.regs;
    assign chanShutdown    = sR.chanShutdown;
    assign refCompChargeOn = sR.refCompChargeOn;
    assign dacLoad         = sR.dacLoad;
    assign dacLoadFromB    = sR.dacLoadFromB;
    assign codeWrite       = sR.codeWrite;
    assign codeWriteToB    = sR.codeWriteToB;
    assign codeValue       = sR.codeValue;
    assign passValid       = sR.passValid;
    assign passFrame       = sR.passFrame;

endmodule

// [hdl/dccd_pkg.sv]
// command codes, field positions, reset values and carrier types of the dac command decoder
// assumes a 32-bit serial frame: one command byte then 24 data bits, msb first
package dccd_pkg;

    localparam int         CHANNELS       = 8;
    localparam logic [4:0] BIT_COUNT_LAST = 5'h1f;

    // command bytes handled here
    localparam logic [7:0] CMD_CONFIG      = 8'h70;
    localparam logic [7:0] CMD_SLEEP       = 8'h71;
    localparam logic [7:0] CMD_PICK        = 8'h72;
    localparam logic [7:0] CMD_SOFT_TOGGLE = 8'h73;
    localparam logic [7:0] CMD_TD_ENABLE   = 8'h74;
    localparam logic [7:0] CMD_MUX         = 8'h75;
    localparam logic [7:0] CMD_FAULT       = 8'h76;
    localparam logic [7:0] CMD_BROADCAST   = 8'h78;
    localparam logic [7:0] CMD_NOP         = 8'hff;

    // command groups recognised by the upper nibble, or by a range
    localparam logic [3:0] NIB_UPDATE       = 4'h6;
    localparam logic [3:0] NIB_READ_GLOBAL  = 4'hf;
    localparam logic [3:0] NIB_CHAN_WR_LAST = 4'h5;
    localparam logic [3:0] NIB_CHAN_RD_LO   = 4'h8;
    localparam logic [3:0] NIB_CHAN_RD_HI   = 4'hb;
    localparam logic [7:0] CMD_EXTRA_LO     = 8'h79;
    localparam logic [7:0] CMD_EXTRA_HI     = 8'h7c;

    // data bit positions inside the 24-bit field
    localparam int SOFT_RESET_BIT   = 23;
    localparam int TRIP_DISABLE_BIT = 10;
    localparam int OUTSIDE_REF_BIT  = 9;
    localparam int SPI_CRC_BIT      = 8;
    localparam int CHAN_LSB         = 8;
    localparam int MUX_ON_BIT       = 18;
    localparam int MUX_SEL_MSB      = 17;
    localparam int MUX_SEL_LSB      = 8;
    localparam int THERMAL_FLAG_BIT = 10;
    localparam int CLOCK_FLAG_BIT   = 9;
    localparam int COMMAND_FLAG_BIT = 8;
    localparam int CODE_MSB         = 23;
    localparam int CODE16_LSB       = 8;
    localparam int CODE12_LSB       = 12;

    typedef struct packed {
        logic [7:0]  cmd;
        logic [23:0] data;
    } dccd_frame_t;

    typedef struct packed {
        logic thermalTripDisable;
        logic outsideReferenceSelect;
        logic spiCrcOn;
    } dccd_config_t;

    typedef struct packed {
        logic thermalTripFlag;
        logic clockIntegrityFlag;
        logic commandIntegrityFlag;
    } dccd_faults_t;

    typedef struct packed {
        dccd_config_t cfg;
        logic [7:0]   channelSleepBits;
        logic [7:0]   inputPickBits;
        logic [7:0]   softToggleBits;
        logic [7:0]   toggleDitherEnableBits;
        logic         monitorMuxOn;
        logic [9:0]   monitorMuxSelect;
        dccd_faults_t faults;
    } dccd_regs_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_EXEC = 2'b01
    } dccd_phase_t;

    typedef struct packed {
        logic        rstMeta;
        logic        rstSync;
        logic [4:0]  bitCount;
        logic [31:0] shiftIn;
        dccd_frame_t frameHold;
        logic        frameToggle;
        logic [31:0] txShift;
        logic        sdo;
    } dccd_link_t;

    typedef struct packed {
        logic        thermMeta;
        logic        thermSync;
        logic [2:0]  pinMeta;
        logic [2:0]  pinSync;
        logic        togMeta;
        logic        togSync;
        logic        togSeen;
        dccd_phase_t phase;
        dccd_frame_t frame;
        dccd_regs_t  regs;
        dccd_frame_t readWord;
        logic [7:0]  toggleLevel;
        logic [7:0]  chanShutdown;
        logic        refCompChargeOn;
        logic [7:0]  dacLoad;
        logic [7:0]  dacLoadFromB;
        logic [7:0]  codeWrite;
        logic [7:0]  codeWriteToB;
        logic [15:0] codeValue;
        logic        passValid;
        dccd_frame_t passFrame;
    } dccd_sys_t;

    localparam dccd_regs_t REGS_RESET = '0;
    localparam dccd_link_t LINK_RESET = '0;
    localparam dccd_sys_t  SYS_RESET  = '{phase: ST_IDLE, refCompChargeOn: 1'b1, default: '0};

endpackage

// [hdl/dccd_link.sv]
// serial link end of the dac command decoder, clocked by the host's serial clock
// assumes the host sends whole 32-bit frames and clocks sclk while rst is high
`timescale 1ns/1ps

module dccd_link (
    // serial pins, sampled on the rising edge of sclk
    input  wire logic                 sclk,
    input  wire logic                 csN,
    input  wire logic                 sdi,
    output logic                      sdo,
    // system side
    input  wire logic                 rst,
    input  wire dccd_pkg::dccd_frame_t readWord,
    output dccd_pkg::dccd_frame_t     frameHold,
    output logic                      frameToggle
);

    dccd_pkg::dccd_link_t sR;
    dccd_pkg::dccd_link_t sN;

    always_comb begin
        sN = sR;
        // reset reaches this domain through two flops
        sN.rstMeta = rst;
        sN.rstSync = sR.rstMeta;
        if (sR.rstSync) begin
            sN = dccd_pkg::LINK_RESET;
            sN.rstMeta = rst;
            sN.rstSync = sR.rstMeta;
        end else if (csN) begin
            // an aborted frame is forgotten at the next edge seen with the select high
            sN.bitCount = '0;
        end else begin
            sN.shiftIn  = {sR.shiftIn[30:0], sdi};
            sN.bitCount = sR.bitCount + 5'h01;
            // readWord is quiet between frames, so loading it on the first edge is safe
            if (sR.bitCount == 5'h00) begin
                sN.txShift = {readWord[30:0], 1'b0};
                sN.sdo     = readWord[31];
            end else begin
                sN.txShift = {sR.txShift[30:0], 1'b0};
                sN.sdo     = sR.txShift[31];
            end
            // the word stays put for a whole frame, long enough for the toggle to cross
            if (sR.bitCount == dccd_pkg::BIT_COUNT_LAST) begin
                sN.frameHold   = {sR.shiftIn[30:0], sdi};
                sN.frameToggle = ~sR.frameToggle;
            end
        end
    end

    always_ff @(posedge sclk) begin
        sR <= sN;
    end

    assign sdo         = sR.sdo;
    assign frameHold   = sR.frameHold;
    assign frameToggle = sR.frameToggle;

endmodule

// [tb/dccd_assertions.sv]
// concurrent checks on the decoder's top-level outputs
// assumes the clk_sys domain only; bound to every dccd_top instance
`timescale 1ns/1ps

module dccd_checker #(
    parameter bit CODE_IS_12BIT = 1'b0
) (
    // clock and reset
    input wire logic                 clk_sys,
    input wire logic                 rst,
    // watched outputs
    input wire dccd_pkg::dccd_regs_t regView,
    input wire logic [7:0]           chanShutdown,
    input wire logic                 refCompChargeOn,
    input wire logic [7:0]           dacLoad,
    input wire logic [7:0]           dacLoadFromB,
    input wire logic [7:0]           codeWrite,
    input wire logic [7:0]           codeWriteToB,
    input wire logic [15:0]          codeValue
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    chk_reset_values: assert property (
        $past(rst) |-> regView == dccd_pkg::REGS_RESET && refCompChargeOn)
        else $error("registers not at defaults after reset");
    chk_reference_comp_node_follow: assert property (
        refCompChargeOn == !$past(regView.cfg.outsideReferenceSelect))
        else $error("reference charge does not follow the reference select");
    chk_trip_disabled: assert property (
        regView.cfg.thermalTripDisable [*3] |-> chanShutdown == 8'h00)
        else $error("channel shut down while trip disabled");
    chk_shutdown_all: assert property (
        chanShutdown == 8'h00 || chanShutdown == 8'hff)
        else $error("thermal shutdown not applied to all channels");
    chk_codewr_pulse: assert property (
        codeWrite != 8'h00 |-> codeWrite == 8'hff ##1 codeWrite == 8'h00)
        else $error("broadcast write not one cycle to all channels");
    chk_pick_copy: assert property (
        codeWrite != 8'h00 |-> codeWriteToB == regView.inputPickBits)
        else $error("broadcast target does not follow pick bits");
    chk_code_twelve: assert property (
        codeWrite != 8'h00 && CODE_IS_12BIT |-> codeValue[15:12] == 4'h0)
        else $error("12-bit code has upper bits set");
    chk_load_source: assert property (
        (dacLoad & dacLoadFromB & ~regView.toggleDitherEnableBits
            & ~$past(regView.toggleDitherEnableBits)) == 8'h00)
        else $error("update from B on a channel without toggle enabled");
endmodule

bind dccd_top dccd_checker #(.CODE_IS_12BIT(CODE_IS_12BIT)) chk_u (
    .clk_sys(clk_sys), .rst(rst), .regView(regView), .chanShutdown(chanShutdown),
    .refCompChargeOn(refCompChargeOn), .dacLoad(dacLoad), .dacLoadFromB(dacLoadFromB),
    .codeWrite(codeWrite), .codeWriteToB(codeWriteToB), .codeValue(codeValue)
);

// [tb/dccd_host_model.sv]
// host end of the 4-wire link: sends 32-bit frames and samples the answer
// assumes callers space frames; sclk stands still outside frames and idle()
`timescale 1ns/1ps

module dccd_host_model (
    // serial pins
    output logic      sclk,
    output logic      csN,
    output logic      sdi,
    input  wire logic sdo
);
    initial begin
        sclk = 1'b0;
        csN  = 1'b1;
        sdi  = 1'b0;
    end
    // clocks with csN high, only to walk the link reset through
    task automatic idle(input int n);
        repeat (n) begin
            #3 sclk = 1'b1;
            #3 sclk = 1'b0;
        end
    endtask
    // no crc word is appended: the decoder only stores the crc bit, it never
    task automatic xfer(input dccd_pkg::dccd_frame_t tx, output dccd_pkg::dccd_frame_t rx);
        csN = 1'b0;
        for (int k = 31; k >= 0; k--) begin
            sdi = tx[k];
            #3 sclk = 1'b1;
            #3 sclk = 1'b0;
            rx[k] = sdo;
        end
        csN = 1'b1;
        // released line shows the inverse so a stale bit is never mistaken for data
        sdi = ~tx[0];
    endtask
endmodule

// [tb/test_dac_config_command_decoder.sv]
// self-checking bench for the dac command decoder, serial frames in, ports compared
// assumes the host model drives the link and the checker is bound to dccd_top
`timescale 1ns/1ps

module test_dac_config_command_decoder;
    logic                  clk_sys, rst, thermalOverload, sclk, csN, sdi, sdo;
    logic                  refCompChargeOn, passValid;
    logic [2:0]            togglePin;
    logic [7:0][1:0]       toggleSourceSelect;
    logic [7:0]            chanShutdown, dacLoad, dacLoadFromB, codeWrite, codeWriteToB;
    logic [15:0]           codeValue, codeValue12;
    dccd_pkg::dccd_regs_t  regView, expRegs;
    dccd_pkg::dccd_frame_t passFrame, rx;
    int                    num_errors, samples_checked, cycles;

    dccd_top dut_u (
        .clk_sys(clk_sys), .rst(rst), .sclk(sclk), .csN(csN), .sdi(sdi), .sdo(sdo),
        .thermalOverload(thermalOverload), .togglePin(togglePin),
        .toggleSourceSelect(toggleSourceSelect), .regView(regView),
        .chanShutdown(chanShutdown), .refCompChargeOn(refCompChargeOn), .dacLoad(dacLoad),
        .dacLoadFromB(dacLoadFromB), .codeWrite(codeWrite), .codeWriteToB(codeWriteToB),
        .codeValue(codeValue), .passValid(passValid), .passFrame(passFrame)
    );
    // 12-bit variant listens on the same link; only its code is compared
    dccd_top #(.CODE_IS_12BIT(1'b1)) dut12_u (
        .clk_sys(clk_sys), .rst(rst), .sclk(sclk), .csN(csN), .sdi(sdi), .sdo(),
        .thermalOverload(thermalOverload), .togglePin(togglePin),
        .toggleSourceSelect(toggleSourceSelect), .regView(), .chanShutdown(),
        .refCompChargeOn(), .dacLoad(), .dacLoadFromB(), .codeWrite(), .codeWriteToB(),
        .codeValue(codeValue12), .passValid(), .passFrame()
    );
    dccd_host_model host_u (.sclk(sclk), .csN(csN), .sdi(sdi), .sdo(sdo));

    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 10000) begin
            num_errors++;
            results();
        end
    end

    task automatic results();
        if (num_errors == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    // the wait covers decode latency and the gap a following read answer needs
    task automatic wr(input logic [7:0] c, input logic [23:0] d);
        host_u.xfer({c, d}, rx);
        repeat (12) @(negedge clk_sys);
    endtask
    task automatic waitPulse();
        int n;
        n = 0;
        @(negedge clk_sys);
        while ({dacLoad, codeWrite, passValid} === 17'h0 && n < 12) begin
            @(negedge clk_sys);
            n++;
        end
    endtask
    task automatic cmdPulse(input logic [7:0] c, input logic [23:0] d);
        host_u.xfer({c, d}, rx);
        waitPulse();
    endtask
    task automatic rd(input logic [7:0] c, input logic [23:0] exp);
        wr(c, 24'h000000);
        host_u.xfer({dccd_pkg::CMD_NOP, 24'h000000}, rx);
        // lets a step pass so a following frame never lowers csN in the same step
        @(negedge clk_sys);
        check("readback", 64'({c, exp}), 64'(rx));
    endtask

    initial begin
        rst = 1'b1;
        thermalOverload = 1'b0;
        togglePin = 3'h0;
        toggleSourceSelect = '0;
        expRegs = dccd_pkg::REGS_RESET;
        fork
            host_u.idle(7);
            repeat (12) @(negedge clk_sys);
        join
        rst = 1'b0;
        host_u.idle(3);
        @(negedge clk_sys);
        check("regs", 64'(expRegs), 64'(regView));
        check("reference_comp_node", 64'h1, 64'(refCompChargeOn));
        wr(8'h70, 24'h7ff7ff);
        expRegs.cfg = 3'b111;
        check("regs", 64'(expRegs), 64'(regView));
        check("reference_comp_node", 64'h0, 64'(refCompChargeOn));
        rd(8'hf0, 24'h000700);
        wr(8'h71, 24'hffa5ff);
        expRegs.channelSleepBits = 8'ha5;
        check("regs", 64'(expRegs), 64'(regView));
        rd(8'hf1, 24'h00a500);
        wr(8'h72, 24'h005a00);
        wr(8'h74, 24'h000200);
        wr(8'h75, 24'hfeb3ff);
        expRegs.inputPickBits = 8'h5a;
        expRegs.toggleDitherEnableBits = 8'h02;
        expRegs.monitorMuxOn = 1'b1;
        expRegs.monitorMuxSelect = 10'h2b3;
        check("regs", 64'(expRegs), 64'(regView));
        wr(8'h76, 24'h000700);
        expRegs.faults = 3'b111;
        check("regs", 64'(expRegs), 64'(regView));
        wr(8'h76, 24'h000000);
        // undefined command only raises the command integrity flag
        wr(8'h77, 24'hffffff);
        expRegs.faults = 3'b001;
        check("regs", 64'(expRegs), 64'(regView));
        wr(8'h76, 24'h000000);
        expRegs.faults = 3'b000;
        for (int ch = 0; ch < 8; ch++) begin
            cmdPulse({dccd_pkg::NIB_UPDATE, 4'(ch)}, 24'h000000);
            check("update", 64'(8'h01 << ch), 64'(dacLoad));
            check("from b", 64'h0, 64'(dacLoadFromB[ch]));
        end
        cmdPulse(8'h78, 24'hbeefff);
        check("code all", 64'hff, 64'(codeWrite));
        check("code", 64'hbeef, 64'(codeValue));
        check("code to b", 64'h5a, 64'(codeWriteToB));
        check("code 12", 64'hbee, 64'(codeValue12));
        // channel 2 toggles too but is not enabled, so only channel 1 loads
        cmdPulse(8'h73, 24'h000600);
        check("toggle up", 64'h02, 64'(dacLoad));
        check("from b", 64'h1, 64'(dacLoadFromB[1]));
        cmdPulse(8'h73, 24'h000000);
        check("toggle down", 64'h02, 64'(dacLoad));
        check("from b", 64'h0, 64'(dacLoadFromB[1]));
        toggleSourceSelect[1] = 2'h2;
        togglePin[1] = 1'b1;
        waitPulse();
        check("pin toggle", 64'h02, 64'(dacLoad));
        check("from b", 64'h1, 64'(dacLoadFromB[1]));
        cmdPulse(8'h05, 24'h123456);
        check("pass", 64'h1, 64'(passValid));
        check("pass frame", 64'h05123456, 64'(passFrame));
        repeat (4) @(negedge clk_sys);
        check("regs", 64'(expRegs), 64'(regView));
        thermalOverload = 1'b1;
        repeat (10) @(negedge clk_sys);
        check("shutdown", 64'h00, 64'(chanShutdown));
        expRegs.faults.thermalTripFlag = 1'b1;
        check("regs", 64'(expRegs), 64'(regView));
        rd(8'hf7, 24'h000400);
        wr(8'h70, 24'h000000);
        check("shutdown", 64'hff, 64'(chanShutdown));
        check("reference_comp_node", 64'h1, 64'(refCompChargeOn));
        thermalOverload = 1'b0;
        wr(8'h70, 24'h800700);
        expRegs = dccd_pkg::REGS_RESET;
        check("regs", 64'(expRegs), 64'(regView));
        results();
    end
endmodule
